//--- hdl/ipa_top.sv
// Maskable interrupt acceptance, priority check and entry sequencing.
// Assumes an APB master on clk and a CPU core giving instruction boundaries.
//
// Functional notes
// - Each source has a 3-bit level; zero disables, one to seven rise.
// - A request is enabled only when its level is above the threshold.
// - Acceptance needs mask flag set, request bit set, level above threshold.
// - Threshold zero admits level one up; threshold seven blocks all maskable.
// - Mask flag, request bits, levels and threshold are separate storage.
// - Use read-modify-write or bit instructions so pending requests survive.
// - Resolve priority at instruction end, start the sequence next cycle.
// - String and repeated multiply-accumulate instructions are suspended for entry.
// - First step reads interrupt number and level from a fixed location.
// - Save flag word, then clear mask, debug, stack select (kept for traps 32-63).
// - Push saved flag word, then program counter, then enter the routine.
// - Threshold takes accepted level; watchdog loads seven, reset zero, others keep.
// - The wait before entry depends on the running instruction, up to thirty.
// - Entry takes 18, 19 or 20 cycles by alignment, 20 on a byte bus.
// - Debugger break adds two cycles, single-step or address match one.
// - Hardware sets request bits, clears on acceptance; software may only clear.
// - Mask flag one admits, zero blocks maskable interrupts; zero after reset.
// - Equal levels resolve by fixed hardware order.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/10ps

module ipa_top
   import ipa_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire ipa_core_t core,
   input wire logic [`IPA_NSRC-1:0] periph_req,
   input wire logic dbc_req,
   input wire logic wdt_req,
   input wire logic step_req,
   input wire logic amatch_req,
   input wire logic swi_req,
   input wire logic [`IPA_NUM_W-1:0] swi_num,
   output ipa_seq_t seq,
   output ipa_flag_t flag_word,
   output ipa_flag_t saved_flag,
   output logic [`IPA_NUM_W-1:0] int_num,
   output ipa_lvl_t int_level
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   ipa_state_t state_q;
   ipa_seq_t seq_q;
   ipa_flag_t flag_q, tmp_q;
   ipa_src_t src_q, src_c;
   ipa_lvl_t [`IPA_NSRC-1:0] lvl_q;
   logic [`IPA_NSRC-1:0] req_q, wr_ctrl;
   logic [`IPA_IDX_W-1:0] idx_q, res_idx;
   ipa_lvl_t acc_lvl_q, res_lvl;
   logic [`IPA_NUM_W-1:0] num_q, num_c, swi_num_q;
   logic [4:0] step_q, len_q, len_c, step_nxt;
   logic res_hit, any_c, boundary, start_c, info_step;
   logic dbc_pend_q, wdt_pend_q, step_pend_q, amatch_pend_q, swi_pend_q;
   logic pready_q, pslverr_q, acc_ph, apb_wr, wr_flag, rd_hit;
   logic [31:0] prdata_q, rd_data;

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign seq = seq_q;
   assign flag_word = flag_q;
   assign saved_flag = tmp_q;
   assign int_num = num_q;
   assign int_level = acc_lvl_q;

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   // One wait state keeps pready and prdata straight from flops.
   assign acc_ph = psel && penable && pready_q;
   assign apb_wr = acc_ph && pwrite;
   assign wr_flag = apb_wr && (paddr == `IPA_OFF_FLAG);

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_hit = 1'b1;
      if (paddr == `IPA_OFF_FLAG) begin
         rd_data[`IPA_FLAG_I_BIT] = flag_q.i;
         rd_data[`IPA_FLAG_D_BIT] = flag_q.d;
         rd_data[`IPA_FLAG_U_BIT] = flag_q.u;
         rd_data[`IPA_FLAG_THR_LSB +: 3] = flag_q.thr;
      end else if (paddr == `IPA_OFF_INFO) begin
         rd_data[`IPA_NUM_W-1:0] = num_q;
         rd_data[`IPA_INFO_LVL_LSB +: 3] = acc_lvl_q;
      end else if (paddr == `IPA_OFF_STAT) begin
         rd_data[4:0] = len_q;
         rd_data[`IPA_STAT_STEP_LSB +: 5] = step_q;
         rd_data[`IPA_STAT_BUSY_BIT] = seq_q.busy;
      end else begin
         rd_hit = 1'b0;
         for (int k = 0; k < `IPA_NSRC; k++) begin
            if (paddr == `IPA_OFF_CTRL0 + 8'(4 * k)) begin
               rd_hit = 1'b1;
               rd_data[2:0] = lvl_q[k];
               rd_data[`IPA_CTRL_REQ_BIT] = req_q[k];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= psel && penable && !pready_q;
         pslverr_q <= psel && penable && !pready_q && !rd_hit;
         if (psel && penable && !pready_q && !pwrite) begin
            prdata_q <= rd_data;
         end
      end
   end

   // ------------------------------------------------------------
   // Per-source control storage
   // ------------------------------------------------------------
   assign info_step = seq_q.info_rd;

   for (genvar g = 0; g < `IPA_NSRC; g++) begin : g_src
      assign wr_ctrl[g] = apb_wr && (paddr == `IPA_OFF_CTRL0 + 8'(4 * g));

      always_ff @(posedge clk) begin
         if (!rst_n) begin
            lvl_q[g] <= `IPA_LVL_RST;
         end else if (wr_ctrl[g]) begin
            lvl_q[g] <= pwdata[2:0];
         end
      end

      // A new request beats both clears, so nothing arriving mid-clear is lost.
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            req_q[g] <= 1'b0;
         end else if (periph_req[g]) begin
            req_q[g] <= 1'b1;
         end else if (info_step && src_q == SRC_PERIPH && idx_q == `IPA_IDX_W'(g)) begin
            req_q[g] <= 1'b0;
         end else if (wr_ctrl[g] && !pwdata[`IPA_CTRL_REQ_BIT]) begin
            req_q[g] <= 1'b0;
         end
      end
   end

   ipa_resolver u_res (
      .req(req_q),
      .lvl(lvl_q),
      .thr(flag_q.thr),
      .hit(res_hit),
      .idx(res_idx),
      .level(res_lvl)
   );

   // ------------------------------------------------------------
   // Pending non-maskable and trap events
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dbc_pend_q <= 1'b0;
         wdt_pend_q <= 1'b0;
         step_pend_q <= 1'b0;
         amatch_pend_q <= 1'b0;
         swi_pend_q <= 1'b0;
      end else begin
         dbc_pend_q <= dbc_req || (dbc_pend_q && !(info_step && src_q == SRC_DBC));
         wdt_pend_q <= wdt_req || (wdt_pend_q && !(info_step && src_q == SRC_WDT));
         step_pend_q <= step_req || (step_pend_q && !(info_step && src_q == SRC_STEP));
         amatch_pend_q <= amatch_req ||
            (amatch_pend_q && !(info_step && src_q == SRC_AMATCH));
         swi_pend_q <= swi_req || (swi_pend_q && !(info_step && src_q == SRC_SWI));
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         swi_num_q <= '0;
      end else if (swi_req) begin
         swi_num_q <= swi_num;
      end
   end

   // ------------------------------------------------------------
   // Acceptance
   // ------------------------------------------------------------
   // Suspendable string and accumulate instructions open a boundary every cycle.
   assign boundary = core.instr_done || core.instr_susp;

   always_comb begin
      src_c = SRC_PERIPH;
      any_c = 1'b1;
      num_c = `IPA_NUM_PERIPH_BASE + `IPA_NUM_W'(res_idx);
      if (dbc_pend_q) begin
         src_c = SRC_DBC;
         num_c = `IPA_NUM_DBC;
      end else if (wdt_pend_q) begin
         src_c = SRC_WDT;
         num_c = `IPA_NUM_WDT;
      end else if (flag_q.i && res_hit) begin
         src_c = SRC_PERIPH;
      end else if (step_pend_q) begin
         src_c = SRC_STEP;
         num_c = `IPA_NUM_STEP;
      end else if (amatch_pend_q) begin
         src_c = SRC_AMATCH;
         num_c = `IPA_NUM_AMATCH;
      end else if (swi_pend_q) begin
         src_c = SRC_SWI;
         num_c = swi_num_q;
      end else begin
         any_c = 1'b0;
      end
   end

   assign start_c = (state_q == ST_IDLE) && boundary && any_c;

   always_comb begin
      len_c = core.bus8 ? `IPA_SEQ_BUS8_CYC :
         `IPA_SEQ_BASE_CYC + 5'(core.vec_odd) + 5'(core.sp_odd);
      if (src_c == SRC_DBC) begin
         len_c = len_c + `IPA_DBC_EXTRA_CYC;
      end else if (src_c == SRC_STEP || src_c == SRC_AMATCH) begin
         len_c = len_c + `IPA_STEP_EXTRA_CYC;
      end
   end

   // ------------------------------------------------------------
   // Entry sequencer
   // ------------------------------------------------------------
   assign step_nxt = step_q + 5'h01;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         step_q <= '0;
         len_q <= '0;
         src_q <= SRC_PERIPH;
         idx_q <= '0;
         acc_lvl_q <= '0;
         num_q <= '0;
         seq_q <= '0;
      end else begin
         seq_q <= '0;
         unique case (state_q)
            ST_IDLE: begin
               if (start_c) begin
                  state_q <= ST_SEQ;
                  step_q <= `IPA_STEP_INFO;
                  len_q <= len_c;
                  src_q <= src_c;
                  idx_q <= res_idx;
                  acc_lvl_q <= (src_c == SRC_PERIPH) ? res_lvl : '0;
                  num_q <= num_c;
                  seq_q.busy <= 1'b1;
                  seq_q.info_rd <= 1'b1;
               end
            end
            ST_SEQ: begin
               if (step_q == len_q - 5'h01) begin
                  state_q <= ST_IDLE;
               end else begin
                  step_q <= step_nxt;
                  seq_q.busy <= 1'b1;
                  seq_q.save_tmp <= step_nxt == `IPA_STEP_TMP;
                  seq_q.clr_flags <= step_nxt == `IPA_STEP_CLR;
                  seq_q.push_flag <= step_nxt == `IPA_STEP_PUSHF;
                  seq_q.push_pc <= step_nxt == `IPA_STEP_PUSHPC;
                  seq_q.enter <= step_nxt == len_q - 5'h01;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Flag word and its saved copy
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tmp_q <= '0;
      end else if (seq_q.save_tmp) begin
         tmp_q <= flag_q;
      end
   end

   // The clear and threshold steps beat an APB write; software cannot run during an entry anyway.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flag_q <= '0;
         flag_q.thr <= `IPA_THR_RST;
      end else if (seq_q.clr_flags) begin
         flag_q.i <= 1'b0;
         flag_q.d <= 1'b0;
         if (!(src_q == SRC_SWI && num_q >= `IPA_SWI_KEEPU_LO)) begin
            flag_q.u <= 1'b0;
         end
      end else if (seq_q.busy && step_q == `IPA_STEP_THR) begin
         if (src_q == SRC_PERIPH) begin
            flag_q.thr <= acc_lvl_q;
         end else if (src_q == SRC_WDT) begin
            flag_q.thr <= `IPA_THR_WDT;
         end
      end else if (wr_flag) begin
         flag_q.i <= pwdata[`IPA_FLAG_I_BIT];
         flag_q.d <= pwdata[`IPA_FLAG_D_BIT];
         flag_q.u <= pwdata[`IPA_FLAG_U_BIT];
         flag_q.thr <= pwdata[`IPA_FLAG_THR_LSB +: 3];
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_accept_cond;
      start_c && src_c == SRC_PERIPH |-> flag_q.i && req_q[res_idx] && res_lvl > flag_q.thr;
   endproperty
   a_accept_cond: assert property (p_accept_cond) else $error("bad acceptance");

   property p_thr_block;
      flag_q.thr == 3'h7 |-> !(start_c && src_c == SRC_PERIPH);
   endproperty
   a_thr_block: assert property (p_thr_block) else $error("threshold 7 leaked");

   property p_boundary;
      start_c |-> boundary ##1 seq_q.info_rd;
   endproperty
   a_boundary: assert property (p_boundary) else $error("start off boundary");

   sequence s_entry;
      seq_q.info_rd ##1 seq_q.save_tmp ##1 seq_q.clr_flags ##1 seq_q.push_flag
         ##1 seq_q.push_pc;
   endsequence
   property p_order;
      seq_q.info_rd |-> s_entry;
   endproperty
   a_order: assert property (p_order) else $error("entry steps out of order");

   property p_clear_flags;
      seq_q.clr_flags && src_q != SRC_SWI |=> !flag_q.i && !flag_q.d && !flag_q.u;
   endproperty
   a_clear_flags: assert property (p_clear_flags) else $error("flags not cleared");

   property p_thr_load;
      seq_q.enter && src_q == SRC_PERIPH |-> flag_q.thr == acc_lvl_q;
   endproperty
   a_thr_load: assert property (p_thr_load) else $error("threshold not loaded");

   property p_thr_wdt;
      seq_q.enter && src_q == SRC_WDT |-> flag_q.thr == 3'h7;
   endproperty
   a_thr_wdt: assert property (p_thr_wdt) else $error("watchdog threshold wrong");

   // Counts entry pulses since the last start, so the length check needs no long repetition.
   logic [1:0] enter_cnt_q;

   always_ff @(posedge clk) begin
      if (!rst_n || start_c) begin
         enter_cnt_q <= 2'h0;
      end else if (seq_q.enter && enter_cnt_q != 2'h3) begin
         enter_cnt_q <= enter_cnt_q + 2'h1;
      end
   end

   property p_len18;
      start_c && src_c == SRC_PERIPH && !core.bus8 && !core.vec_odd && !core.sp_odd
         |=> ##17 (seq_q.enter && enter_cnt_q == 2'h0) ##1 !seq_q.busy;
   endproperty
   a_len18: assert property (p_len18) else $error("entry not 18 cycles");

   property p_dbc_len;
      start_c && src_c == SRC_DBC && !core.bus8 && !core.vec_odd && !core.sp_odd
         |=> ##19 seq_q.enter;
   endproperty
   a_dbc_len: assert property (p_dbc_len) else $error("break entry not 20 cycles");

   property p_req_clear;
      seq_q.info_rd && src_q == SRC_PERIPH && !periph_req[idx_q] |=> !req_q[idx_q];
   endproperty
   a_req_clear: assert property (p_req_clear) else $error("request bit kept");

   property p_set_wins;
      periph_req[0] |=> req_q[0];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("request lost");

endmodule

//--- hdl/ipa_cfg.svh
// Offsets, field positions, reset values and timing counts of the acceptance block.
// Assumes inclusion by bare name from the package only; the design modules do not include it.
`ifndef IPA_CFG_SVH
`define IPA_CFG_SVH

`define IPA_NSRC 8
`define IPA_IDX_W 3
`define IPA_NUM_W 6

`define IPA_OFF_CTRL0 8'h00
`define IPA_OFF_FLAG 8'h20
`define IPA_OFF_INFO 8'h24
`define IPA_OFF_STAT 8'h28

`define IPA_CTRL_REQ_BIT 3
`define IPA_FLAG_I_BIT 0
`define IPA_FLAG_D_BIT 1
`define IPA_FLAG_U_BIT 2
`define IPA_FLAG_THR_LSB 4
`define IPA_INFO_LVL_LSB 8
`define IPA_STAT_STEP_LSB 8
`define IPA_STAT_BUSY_BIT 16

`define IPA_LVL_RST 3'h0
`define IPA_THR_RST 3'h0
`define IPA_THR_WDT 3'h7

`define IPA_SEQ_BASE_CYC 5'h12
`define IPA_SEQ_BUS8_CYC 5'h14
`define IPA_DBC_EXTRA_CYC 5'h02
`define IPA_STEP_EXTRA_CYC 5'h01

`define IPA_STEP_INFO 5'h00
`define IPA_STEP_TMP 5'h01
`define IPA_STEP_CLR 5'h02
`define IPA_STEP_PUSHF 5'h03
`define IPA_STEP_PUSHPC 5'h04
`define IPA_STEP_THR 5'h05

`define IPA_NUM_PERIPH_BASE 6'h04
`define IPA_NUM_DBC 6'h3c
`define IPA_NUM_WDT 6'h3d
`define IPA_NUM_STEP 6'h3e
`define IPA_NUM_AMATCH 6'h3f
`define IPA_SWI_KEEPU_LO 6'h20

`endif

//--- hdl/ipa_pkg.sv
// Types shared by the acceptance block and its priority resolver.
// Assumes ipa_cfg.svh is on the include path.
`include "ipa_cfg.svh"

package ipa_pkg;

   typedef logic [2:0] ipa_lvl_t;

   typedef struct packed {
      logic instr_done;
      logic instr_susp;
      logic vec_odd;
      logic sp_odd;
      logic bus8;
   } ipa_core_t;

   typedef struct packed {
      logic busy;
      logic info_rd;
      logic save_tmp;
      logic clr_flags;
      logic push_flag;
      logic push_pc;
      logic enter;
   } ipa_seq_t;

   typedef struct packed {
      ipa_lvl_t thr;
      logic u;
      logic d;
      logic i;
   } ipa_flag_t;

   typedef enum logic [2:0] {
      SRC_PERIPH, SRC_DBC, SRC_WDT, SRC_STEP, SRC_AMATCH, SRC_SWI
   } ipa_src_t;

   typedef enum logic {
      ST_IDLE, ST_SEQ
   } ipa_state_t;

endpackage

//--- hdl/ipa_resolver.sv
// Priority level resolution among the peripheral request sources.
// Assumes request bits, levels and threshold come from flops on the same clock.
`timescale 1ns/10ps

module ipa_resolver
   import ipa_pkg::*;
(
   input wire logic [`IPA_NSRC-1:0] req,
   input wire ipa_lvl_t [`IPA_NSRC-1:0] lvl,
   input wire ipa_lvl_t thr,
   output logic hit,
   output logic [`IPA_IDX_W-1:0] idx,
   output ipa_lvl_t level
);

   logic [`IPA_NSRC-1:0] en;

   // Level zero can never exceed a threshold, so it disables the source.
   for (genvar g = 0; g < `IPA_NSRC; g++) begin : g_en
      assign en[g] = req[g] && (lvl[g] > thr);
   end

   // Scanning from the top with >= lets the lower index win a tie.
   always_comb begin
      hit = 1'b0;
      idx = '0;
      level = '0;
      for (int k = `IPA_NSRC - 1; k >= 0; k--) begin
         if (en[k] && (!hit || lvl[k] >= level)) begin
            hit = 1'b1;
            idx = `IPA_IDX_W'(k);
            level = lvl[k];
         end
      end
   end

endmodule

//--- dv/ipa_core_model.sv
// Behavioural CPU core that gives instruction boundaries to the acceptance block.
// Assumes the same clock as the block; the core stalls while an entry runs.
`timescale 1ns/10ps

module ipa_core_model
   import ipa_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic busy,
   input wire logic [4:0] instr_len,
   input wire logic susp,
   input wire logic vec_odd,
   input wire logic sp_odd,
   input wire logic bus8,
   output ipa_core_t core
);
   logic [4:0] cnt_q;

   // The count reloads during an entry, so the first boundary after it is predictable.
   always_ff @(posedge clk) begin
      if (!rst_n || busy || cnt_q == 5'h00) begin
         cnt_q <= instr_len;
      end else begin
         cnt_q <= cnt_q - 5'h01;
      end
   end

   always_comb begin
      core.instr_done = rst_n && !busy && (cnt_q == 5'h00);
      core.instr_susp = susp && !busy;
      core.vec_odd = vec_odd;
      core.sp_odd = sp_odd;
      core.bus8 = bus8;
   end
endmodule

//--- dv/tb_interrupt_priority_acceptance.sv
// Self-checking bench for the interrupt acceptance block.
// Assumes the core model in ipa_core_model.sv and the design under hdl.
`timescale 1ns/10ps

module tb_interrupt_priority_acceptance
   import ipa_pkg::*;
;
   typedef struct packed {
      logic [2:0] lvl;
      logic [2:0] thr;
      logic ie;
      logic vo;
      logic so;
      logic b8;
      logic acc;
      logic [4:0] len;
   } ipa_row_t;

   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr, periph_req;
   logic [31:0] pwdata, prdata, rd;
   logic dbc_req, wdt_req, step_req, amatch_req, swi_req, susp, vec_odd, sp_odd, bus8;
   logic [`IPA_NUM_W-1:0] swi_num, int_num;
   logic [4:0] instr_len;
   ipa_core_t core;
   ipa_seq_t seq;
   ipa_flag_t flag_word, saved_flag;
   ipa_lvl_t int_level;
   int n_mismatch, checked;
   ipa_row_t r;
   ipa_row_t rows[8] = '{
      '{3'h1, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 5'h12},
      '{3'h7, 3'h6, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 5'h13},
      '{3'h7, 3'h7, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00},
      '{3'h3, 3'h3, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00},
      '{3'h4, 3'h3, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 5'h14},
      '{3'h5, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00},
      '{3'h0, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00},
      '{3'h2, 3'h1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 5'h14}};
   logic [5:0] snum[4] = '{`IPA_NUM_DBC, `IPA_NUM_WDT, `IPA_NUM_STEP, `IPA_NUM_AMATCH};
   logic [4:0] slen[4] = '{5'h14, 5'h12, 5'h13, 5'h13};
   logic [2:0] sthr[4] = '{3'h2, 3'h7, 3'h2, 3'h2};

   ipa_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .core(core), .periph_req(periph_req), .dbc_req(dbc_req), .wdt_req(wdt_req),
      .step_req(step_req), .amatch_req(amatch_req), .swi_req(swi_req), .swi_num(swi_num),
      .seq(seq), .flag_word(flag_word), .saved_flag(saved_flag), .int_num(int_num),
      .int_level(int_level));

   ipa_core_model cpu (.clk(clk), .rst_n(rst_n), .busy(seq.busy), .instr_len(instr_len),
      .susp(susp), .vec_odd(vec_odd), .sp_odd(sp_odd), .bus8(bus8), .core(core));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int w;
      w = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         w++;
      end while (pready !== 1'b1 && w < 20);
      if (pready !== 1'b1) begin
         n_mismatch++;
         wrap_up();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [31:0] fw(input logic [2:0] t, input logic [2:0] udi);
      return {25'h0, t, 1'b0, udi};
   endfunction

   // The two quiet edges after the pulse stand for the settling gap before unmasking.
   task automatic pulse(input logic [7:0] p, input logic [4:0] s);
      @(posedge clk);
      periph_req <= p;
      {swi_req, amatch_req, step_req, wdt_req, dbc_req} <= s;
      @(posedge clk);
      periph_req <= 8'h00;
      {swi_req, amatch_req, step_req, wdt_req, dbc_req} <= 5'h00;
      repeat (2) @(posedge clk);
   endtask

   task automatic run_entry(input logic [5:0] num, input logic [4:0] len,
      input logic [2:0] thr, input int wmax);
      int w;
      int c;
      logic ent;
      w = 0;
      c = 0;
      ent = 1'b0;
      while (seq.busy !== 1'b1 && w < wmax) begin
         @(posedge clk);
         w++;
      end
      if (seq.busy !== 1'b1) begin
         n_mismatch++;
         wrap_up();
      end
      while (seq.busy === 1'b1 && c < 40) begin
         ent = seq.enter;
         c++;
         @(posedge clk);
      end
      chk(32'(c), 32'(len));
      chk(32'(ent), 32'h1);
      chk(32'(int_num), 32'(num));
      chk(32'(flag_word.thr), 32'(thr));
      chk(32'(flag_word.i), 32'h0);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata, periph_req, swi_num} = '0;
      {dbc_req, wdt_req, step_req, amatch_req, swi_req, susp, vec_odd, sp_odd, bus8} = '0;
      instr_len = 5'h03;
      n_mismatch = 0;
      checked = 0;
      rst_n = 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, `IPA_OFF_FLAG, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, `IPA_OFF_CTRL0, 32'hd);
      apb(1'b0, `IPA_OFF_CTRL0, 32'h0);
      chk(rd, 32'h5);
      apb(1'b1, `IPA_OFF_CTRL0 + 8'h04, 32'h6);
      apb(1'b0, `IPA_OFF_CTRL0, 32'h0);
      chk(rd, 32'h5);
      apb(1'b0, `IPA_OFF_FLAG, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk(32'(er), 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, `IPA_OFF_CTRL0 + 8'h04, 32'h0);
      $display("test reset done");
      foreach (rows[k]) begin
         r = rows[k];
         vec_odd <= r.vo;
         sp_odd <= r.so;
         bus8 <= r.b8;
         apb(1'b1, `IPA_OFF_FLAG, fw(r.thr, 3'h0));
         apb(1'b1, `IPA_OFF_CTRL0, {29'h0, r.lvl});
         pulse(8'h01, 5'h00);
         apb(1'b1, `IPA_OFF_FLAG, fw(r.thr, {2'b00, r.ie}));
         if (r.acc) begin
            run_entry(`IPA_NUM_PERIPH_BASE, r.len, r.lvl, 80);
            chk(32'(int_level), 32'(r.lvl));
         end else begin
            er = 1'b0;
            repeat (40) begin
               @(posedge clk);
               #1;
               er = er | seq.busy;
            end
            chk(32'(er), 32'h0);
            apb(1'b1, `IPA_OFF_CTRL0, 32'h0);
         end
      end
      {vec_odd, sp_odd, bus8} <= 3'h0;
      $display("test rows done");
      apb(1'b1, `IPA_OFF_FLAG, fw(3'h0, 3'h0));
      apb(1'b1, `IPA_OFF_CTRL0 + 8'h04, 32'h4);
      apb(1'b1, `IPA_OFF_CTRL0 + 8'h08, 32'h4);
      pulse(8'h06, 5'h00);
      apb(1'b1, `IPA_OFF_FLAG, fw(3'h0, 3'h1));
      run_entry(`IPA_NUM_PERIPH_BASE + 6'h01, 5'h12, 3'h4, 80);
      apb(1'b0, `IPA_OFF_CTRL0 + 8'h04, 32'h0);
      chk(rd, 32'h4);
      apb(1'b0, `IPA_OFF_CTRL0 + 8'h08, 32'h0);
      chk(rd, 32'hc);
      apb(1'b1, `IPA_OFF_FLAG, fw(3'h3, 3'h1));
      run_entry(`IPA_NUM_PERIPH_BASE + 6'h02, 5'h12, 3'h4, 80);
      apb(1'b1, `IPA_OFF_CTRL0 + 8'h04, 32'h0);
      apb(1'b1, `IPA_OFF_CTRL0 + 8'h08, 32'h0);
      $display("test tie done");
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, `IPA_OFF_FLAG, fw(3'h2, 3'h0));
         pulse(8'h00, 5'h01 << k);
         run_entry(snum[k], slen[k], sthr[k], 80);
      end
      $display("test special done");
      for (int k = 0; k < 2; k++) begin
         swi_num <= (k == 0) ? 6'h28 : 6'h05;
         apb(1'b1, `IPA_OFF_FLAG, fw(3'h1, 3'h6));
         pulse(8'h00, 5'h10);
         run_entry((k == 0) ? 6'h28 : 6'h05, 5'h12, 3'h1, 80);
         chk(32'(flag_word.u), (k == 0) ? 32'h1 : 32'h0);
         chk(32'(flag_word.d), 32'h0);
         chk(32'(saved_flag), 32'h0e);
      end
      $display("test trap done");
      instr_len <= 5'h1f;
      susp <= 1'b1;
      apb(1'b1, `IPA_OFF_FLAG, fw(3'h0, 3'h0));
      apb(1'b1, `IPA_OFF_CTRL0, 32'h3);
      pulse(8'h01, 5'h00);
      apb(1'b1, `IPA_OFF_FLAG, fw(3'h0, 3'h1));
      run_entry(`IPA_NUM_PERIPH_BASE, 5'h12, 3'h3, 6);
      susp <= 1'b0;
      $display("test suspend done");
      wrap_up();
   end
endmodule
